// file: common/ddi_pkg.sv
// constants and types for the descriptor intake block
`default_nettype none
package ddi_pkg;
	localparam int STD_WORDS = 4;
	localparam int EXT_WORDS = 8;
	localparam int WORD_BITS = 32;
	localparam int BYTE_BITS = 8;
	localparam int EXT_BITS = EXT_WORDS * WORD_BITS;
	// byte offsets inside a descriptor
	localparam int OFS_SRC_LO = 'h00;
	localparam int OFS_DST_LO = 'h04;
	localparam int OFS_LEN = 'h08;
	localparam int OFS_SEQ_BURST = 'h0C;
	localparam int OFS_STRIDE = 'h10;
	localparam int OFS_SRC_HI = 'h14;
	localparam int OFS_DST_HI = 'h18;
	localparam int OFS_CTRL_STD = 'h0C;
	localparam int OFS_CTRL_EXT = 'h1C;
	// field positions
	localparam int SEQ_LSB = 0;
	localparam int SEQ_W = 16;
	localparam int RD_BURST_LSB = 16;
	localparam int WR_BURST_LSB = 24;
	localparam int BURST_W = 8;
	localparam int RD_STRIDE_LSB = 0;
	localparam int WR_STRIDE_LSB = 16;
	localparam int STRIDE_W = 16;
	localparam int COMMIT_BIT = 31;
	// burst limits
	localparam int BURST_CNT_W = 11;
	localparam int MAX_BURST_DEFAULT = 1024;
	localparam int MAX_BURST_LIMIT = 1024;
	localparam logic [10:0] BURST_CAP = 11'h080;
	// reset and special values
	localparam logic [15:0] STRIDE_SEQUENTIAL = 16'h0001;
	localparam logic [31:0] STRIDE_PAIR_RESET = 32'h0001_0001;
	localparam logic [31:0] LEN_UNLIMITED = 32'hFFFF_FFFF;
	localparam int HOST_DATA_BYTES_DEFAULT = 4;
	localparam int HOST_DATA_BYTES_LIMIT = 128;
	typedef enum logic [1:0] {
		DDI_MM_TO_MM = 2'h0,
		DDI_MM_TO_ST = 2'h1,
		DDI_ST_TO_MM = 2'h2
	} ddi_mode_t;
	typedef enum logic [1:0] {
		DDI_SLOT_EMPTY = 2'b01,
		DDI_SLOT_FULL  = 2'b10
	} ddi_slot_t;
endpackage
`default_nettype wire

// file: core/ddi_intake.sv
// descriptor intake: byte-lane staging, commit, decode and hand-off to the hosts
// Behaviour
// - port is 128 bits standard, 256 extended
// - standard words: source, destination, length, control
// - offset 0xC: sequence, read burst, write burst
// - every byte lane written independently by enables
// - control top bit commits; earlier writes stay staged
// - commit is control bit 31, written last
// - control is the last descriptor word
// - address unused by the mode is ignored
// - upper address words only in extended format
// - length gives bytes per descriptor
// - length caps packet; all ones is unlimited
// - sequence number tracked per host, readable
// - burst fields eight bits, valid 1 to 128
// - zero burst becomes configured maximum, up to 1024
// - burst above 128 gives 128
// - programmable burst enabled per host
// - strides at 0x10, counted in host words
// - stride defaults to one word
// - stride zero repeats, two skips words
// - source and destination strides kept independently
`timescale 1ns/1ps
`default_nettype none
module ddi_intake #(
	parameter bit                 EXTENDED        = 1'b1,
	parameter ddi_pkg::ddi_mode_t MODE            = ddi_pkg::DDI_MM_TO_MM,
	parameter bit                 PROG_BURST_RD   = 1'b1,
	parameter bit                 PROG_BURST_WR   = 1'b1,
	parameter bit                 STRIDE_EN       = 1'b1,
	parameter int                 MAX_BURST       = ddi_pkg::MAX_BURST_DEFAULT,
	parameter int                 HOST_DATA_BYTES = ddi_pkg::HOST_DATA_BYTES_DEFAULT,
	localparam int                WORDS           = EXTENDED ? ddi_pkg::EXT_WORDS : ddi_pkg::STD_WORDS,
	localparam int                PB              = WORDS * 4,
	localparam int                PW              = PB * ddi_pkg::BYTE_BITS
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          agent_write,
	input  wire logic [PB-1:0] agent_byteenable,
	input  wire logic [PW-1:0] agent_writedata,
	output logic               agent_waitrequest,
	input  wire logic          rd_desc_ready,
	input  wire logic          wr_desc_ready,
	output logic               rd_desc_valid,
	output logic               wr_desc_valid,
	output logic [63:0]        desc_src_addr,
	output logic [63:0]        desc_dst_addr,
	output logic [31:0]        desc_length,
	output logic               desc_length_unlimited,
	output logic [31:0]        desc_control,
	output logic [15:0]        desc_seq,
	output logic [10:0]        desc_rd_burst,
	output logic [10:0]        desc_wr_burst,
	output logic [31:0]        desc_rd_stride_bytes,
	output logic [31:0]        desc_wr_stride_bytes,
	output logic [15:0]        rd_seq_status,
	output logic [15:0]        wr_seq_status
);
	localparam int CTRL_OFS = EXTENDED ? ddi_pkg::OFS_CTRL_EXT : ddi_pkg::OFS_CTRL_STD;
	localparam int CTRL_LANE = CTRL_OFS + 3;
	localparam int STRIDE_SHIFT = $clog2(HOST_DATA_BYTES);
	localparam logic [10:0] MAX_BURST_L = 11'(MAX_BURST);
	localparam bit USES_RD = (MODE != ddi_pkg::DDI_ST_TO_MM);
	localparam bit USES_WR = (MODE != ddi_pkg::DDI_MM_TO_ST);
	localparam bit BURST_RD_ON = EXTENDED && PROG_BURST_RD;
	localparam bit BURST_WR_ON = EXTENDED && PROG_BURST_WR;
	localparam bit STRIDE_ON = EXTENDED && STRIDE_EN;

	generate
		if (MAX_BURST < 1 || MAX_BURST > ddi_pkg::MAX_BURST_LIMIT ||
				HOST_DATA_BYTES < 1 || HOST_DATA_BYTES > ddi_pkg::HOST_DATA_BYTES_LIMIT ||
				(HOST_DATA_BYTES & (HOST_DATA_BYTES - 1)) != 0 ||
				MODE == 2'h3) begin : g_bad_cfg
			$error("ddi_intake: unsupported parameter values");
		end
	endgenerate

	// zero or disabled takes the maximum
	function automatic logic [10:0] eff_burst(input logic [7:0] raw, input logic en);
		if (!en || raw == 8'h00) begin
			return MAX_BURST_L;
		end else if ({3'h0, raw} > ddi_pkg::BURST_CAP) begin
			return ddi_pkg::BURST_CAP;
		end else begin
			return {3'h0, raw};
		end
	endfunction

	// words scaled to bytes by host width
	function automatic logic [31:0] stride_bytes(input logic [15:0] raw, input logic en);
		logic [15:0] s;
		s = en ? raw : ddi_pkg::STRIDE_SEQUENTIAL;
		// zero and two kept as written
		return {16'h0000, s} << STRIDE_SHIFT;
	endfunction

	function automatic logic [63:0] addr_at(input logic [ddi_pkg::EXT_BITS-1:0] f, input int lo_ofs,
			input int hi_ofs, input bit used);
		logic [31:0] hi;
		// standard format drops the high word, so addresses alias low
		hi = EXTENDED ? f[hi_ofs*8 +: 32] : 32'h0000_0000;
		if (!used) begin
			return 64'h0000_0000_0000_0000;
		end
		return {hi, f[lo_ofs*8 +: 32]};
	endfunction

	function automatic logic [PW-1:0] stage_init();
		logic [PW-1:0] v;
		v = '0;
		for (int i = 0; i < PW; i++) begin
			if (STRIDE_ON && i >= ddi_pkg::OFS_STRIDE * 8 && i < ddi_pkg::OFS_STRIDE * 8 + 32) begin
				v[i] = ddi_pkg::STRIDE_PAIR_RESET[i - ddi_pkg::OFS_STRIDE * 8];
			end
		end
		return v;
	endfunction

	logic [PW-1:0]                stage_ff;
	logic [PW-1:0]                merged;
	logic [ddi_pkg::EXT_BITS-1:0] full;
	logic                         wr_accept;
	logic                         commit;
	ddi_pkg::ddi_slot_t           slot_ff;
	ddi_pkg::ddi_slot_t           nxt_slot;
	logic                         nxt_rd_valid;
	logic                         nxt_wr_valid;
	logic                         waitrequest_ff;
	logic                         rd_valid_ff;
	logic                         wr_valid_ff;
	logic [63:0]                  src_ff;
	logic [63:0]                  dst_ff;
	logic [31:0]                  len_ff;
	logic                         unlim_ff;
	logic [31:0]                  ctrl_ff;
	logic [15:0]                  seq_ff;
	logic [10:0]                  rd_burst_ff;
	logic [10:0]                  wr_burst_ff;
	logic [31:0]                  rd_stride_ff;
	logic [31:0]                  wr_stride_ff;
	logic [15:0]                  rd_seq_ff;
	logic [15:0]                  wr_seq_ff;

	// writes wait while the slot is held
	assign wr_accept = agent_write && !waitrequest_ff;

	always_comb begin
		for (int b = 0; b < PB; b++) begin
			merged[b*8 +: 8] = agent_byteenable[b] ? agent_writedata[b*8 +: 8] : stage_ff[b*8 +: 8];
		end
		full = (ddi_pkg::EXT_BITS)'(merged);
	end

	// commit on bit 31 of the last word
	always_comb begin
		commit = wr_accept && agent_byteenable[CTRL_LANE] &&
			agent_writedata[CTRL_OFS*8 + ddi_pkg::COMMIT_BIT];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stage_ff <= stage_init();
		end else if (wr_accept) begin
			stage_ff <= merged;
		end
	end

	always_comb begin
		nxt_rd_valid = rd_valid_ff;
		nxt_wr_valid = wr_valid_ff;
		if (rd_valid_ff && rd_desc_ready) begin
			nxt_rd_valid = 1'b0;
		end
		if (wr_valid_ff && wr_desc_ready) begin
			nxt_wr_valid = 1'b0;
		end
		if (commit) begin
			nxt_rd_valid = USES_RD;
			nxt_wr_valid = USES_WR;
		end
		case (slot_ff)
			ddi_pkg::DDI_SLOT_EMPTY: nxt_slot = commit ? ddi_pkg::DDI_SLOT_FULL : ddi_pkg::DDI_SLOT_EMPTY;
			ddi_pkg::DDI_SLOT_FULL: begin
				nxt_slot = (nxt_rd_valid || nxt_wr_valid) ? ddi_pkg::DDI_SLOT_FULL : ddi_pkg::DDI_SLOT_EMPTY;
			end
			default: nxt_slot = ddi_pkg::DDI_SLOT_EMPTY;
		endcase
	end

	// one slot stands in for the dispatcher buffer: depth traded for area, so writes stall more often
	// stall while the buffer holds a descriptor
	always_ff @(posedge clk) begin
		if (reset) begin
			slot_ff <= ddi_pkg::DDI_SLOT_EMPTY;
			waitrequest_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
			wr_valid_ff <= 1'b0;
		end else begin
			slot_ff <= nxt_slot;
			waitrequest_ff <= (nxt_slot == ddi_pkg::DDI_SLOT_FULL);
			rd_valid_ff <= nxt_rd_valid;
			wr_valid_ff <= nxt_wr_valid;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			src_ff <= 64'h0000_0000_0000_0000;
			dst_ff <= 64'h0000_0000_0000_0000;
		end else if (commit) begin
			src_ff <= addr_at(full, ddi_pkg::OFS_SRC_LO, ddi_pkg::OFS_SRC_HI, USES_RD);
			dst_ff <= addr_at(full, ddi_pkg::OFS_DST_LO, ddi_pkg::OFS_DST_HI, USES_WR);
		end
	end

	// decode is captured only at commit, so partial edits never leak out
	always_ff @(posedge clk) begin
		if (reset) begin
			len_ff <= 32'h0000_0000;
			unlim_ff <= 1'b0;
			ctrl_ff <= 32'h0000_0000;
		end else if (commit) begin
			len_ff <= full[ddi_pkg::OFS_LEN*8 +: 32];
			// all ones lifts the packet cap
			unlim_ff <= (full[ddi_pkg::OFS_LEN*8 +: 32] == ddi_pkg::LEN_UNLIMITED);
			ctrl_ff <= full[CTRL_OFS*8 +: 32];
		end
	end

	// sequence and bursts share one word
	always_ff @(posedge clk) begin
		if (reset) begin
			seq_ff <= 16'h0000;
			rd_burst_ff <= MAX_BURST_L;
			wr_burst_ff <= MAX_BURST_L;
		end else if (commit) begin
			seq_ff <= EXTENDED ? full[ddi_pkg::OFS_SEQ_BURST*8 + ddi_pkg::SEQ_LSB +: ddi_pkg::SEQ_W] : 16'h0000;
			rd_burst_ff <= eff_burst(full[ddi_pkg::OFS_SEQ_BURST*8 + ddi_pkg::RD_BURST_LSB +: ddi_pkg::BURST_W],
				BURST_RD_ON);
			wr_burst_ff <= eff_burst(full[ddi_pkg::OFS_SEQ_BURST*8 + ddi_pkg::WR_BURST_LSB +: ddi_pkg::BURST_W],
				BURST_WR_ON);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_stride_ff <= stride_bytes(ddi_pkg::STRIDE_SEQUENTIAL, 1'b0);
			wr_stride_ff <= stride_bytes(ddi_pkg::STRIDE_SEQUENTIAL, 1'b0);
		end else if (commit) begin
			rd_stride_ff <= stride_bytes(full[ddi_pkg::OFS_STRIDE*8 + ddi_pkg::RD_STRIDE_LSB +: ddi_pkg::STRIDE_W],
				STRIDE_ON);
			wr_stride_ff <= stride_bytes(full[ddi_pkg::OFS_STRIDE*8 + ddi_pkg::WR_STRIDE_LSB +: ddi_pkg::STRIDE_W],
				STRIDE_ON);
		end
	end

	// each host latches the sequence it took
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_seq_ff <= 16'h0000;
			wr_seq_ff <= 16'h0000;
		end else begin
			if (rd_valid_ff && rd_desc_ready) begin
				rd_seq_ff <= seq_ff;
			end
			if (wr_valid_ff && wr_desc_ready) begin
				wr_seq_ff <= seq_ff;
			end
		end
	end

	assign agent_waitrequest = waitrequest_ff;
	assign rd_desc_valid = rd_valid_ff;
	assign wr_desc_valid = wr_valid_ff;
	assign desc_src_addr = src_ff;
	assign desc_dst_addr = dst_ff;
	assign desc_length = len_ff;
	assign desc_length_unlimited = unlim_ff;
	assign desc_control = ctrl_ff;
	assign desc_seq = seq_ff;
	assign desc_rd_burst = rd_burst_ff;
	assign desc_wr_burst = wr_burst_ff;
	assign desc_rd_stride_bytes = rd_stride_ff;
	assign desc_wr_stride_bytes = wr_stride_ff;
	assign rd_seq_status = rd_seq_ff;
	assign wr_seq_status = wr_seq_ff;
endmodule // ddi_intake
`default_nettype wire

// file: tb/ddi_intake_monitor.sv
// port assertions for the descriptor intake
`timescale 1ns/1ps
`default_nettype none
module ddi_intake_monitor #(
	parameter bit                 EXTENDED  = 1'b1,
	parameter int                 MAX_BURST = 1024,
	parameter ddi_pkg::ddi_mode_t MODE      = ddi_pkg::DDI_MM_TO_MM,
	localparam int                PB        = EXTENDED ? 32 : 16,
	localparam int                PW        = PB * 8
) (
	input wire logic          clk,
	input wire logic          reset,
	input wire logic          agent_write,
	input wire logic [PB-1:0] agent_byteenable,
	input wire logic [PW-1:0] agent_writedata,
	input wire logic          agent_waitrequest,
	input wire logic          rd_desc_ready,
	input wire logic          wr_desc_ready,
	input wire logic          rd_desc_valid,
	input wire logic          wr_desc_valid,
	input wire logic [31:0]   desc_length,
	input wire logic          desc_length_unlimited,
	input wire logic [31:0]   desc_control,
	input wire logic [15:0]   desc_seq,
	input wire logic [10:0]   desc_rd_burst,
	input wire logic [15:0]   rd_seq_status,
	input wire logic [15:0]   wr_seq_status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// taken write whose top control lane carries the commit bit
	sequence commit_s;
		agent_write && !agent_waitrequest && agent_byteenable[PB-1] && agent_writedata[PW-1];
	endsequence
	sequence idle_s;
		!rd_desc_valid && !wr_desc_valid;
	endsequence
	commit_go_a: assert property (commit_s |=> rd_desc_valid == (MODE != ddi_pkg::DDI_ST_TO_MM) &&
		wr_desc_valid == (MODE != ddi_pkg::DDI_MM_TO_ST))
		else $error("commit write gave no descriptor");
	no_commit_a: assert property (idle_s ##0 agent_write && !agent_writedata[PW-1] |=> idle_s)
		else $error("descriptor offered without commit");
	wait_full_a: assert property (agent_waitrequest == (rd_desc_valid || wr_desc_valid))
		else $error("stall does not follow held descriptor");
	rd_hold_a: assert property (rd_desc_valid && !rd_desc_ready |=> rd_desc_valid && $stable(desc_seq))
		else $error("descriptor dropped before read host took it");
	rd_take_a: assert property (rd_desc_valid && rd_desc_ready |=> !rd_desc_valid && rd_seq_status == $past(desc_seq))
		else $error("read host sequence status wrong");
	wr_take_a: assert property (wr_desc_valid && wr_desc_ready |=> !wr_desc_valid && wr_seq_status == $past(desc_seq))
		else $error("write host sequence status wrong");
	burst_range_a: assert property (rd_desc_valid |-> desc_rd_burst inside {[11'h001:11'h080]} || desc_rd_burst == MAX_BURST)
		else $error("read burst out of range");
	commit_bit_a: assert property (rd_desc_valid |-> desc_control[31])
		else $error("offered control word lacks commit bit");
	len_flag_a: assert property (desc_length_unlimited == (desc_length == 32'hFFFF_FFFF))
		else $error("unlimited length flag wrong");
endmodule // ddi_intake_monitor
bind ddi_intake ddi_intake_monitor #(.EXTENDED(EXTENDED), .MAX_BURST(MAX_BURST), .MODE(MODE)) mon (.clk, .reset,
	.agent_write,
	.agent_byteenable, .agent_writedata, .agent_waitrequest, .rd_desc_ready, .wr_desc_ready, .rd_desc_valid,
	.wr_desc_valid, .desc_length, .desc_length_unlimited, .desc_control, .desc_seq, .desc_rd_burst,
	.rd_seq_status, .wr_seq_status);
`default_nettype wire

// file: tb/ddi_writer_model.sv
// descriptor writer standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module ddi_writer_model (
	input  wire logic         clk,
	input  wire logic         go,
	input  wire logic [31:0]  be,
	input  wire logic [255:0] data,
	input  wire logic         agent_waitrequest,
	output logic              agent_write,
	output logic [31:0]       agent_byteenable,
	output logic [255:0]      agent_writedata
);
	initial begin
		agent_write = 1'b0;
		agent_byteenable = 32'h0000_0000;
		agent_writedata = '0;
	end
	// caller orders fields
	// mm-to-mm needs both addresses and the length; commit lane rides last
	// request held until taken, released data lines then scrambled
	always @(posedge clk) begin
		if (go && !agent_write) begin
			agent_write <= 1'b1;
			agent_byteenable <= be;
			agent_writedata <= data;
		end else if (agent_write && !agent_waitrequest) begin
			agent_write <= 1'b0;
			agent_byteenable <= 32'h0000_0000;
			agent_writedata <= ~agent_writedata;
		end
	end
endmodule // ddi_writer_model
`default_nettype wire

// file: tb/ddi_intake_tb.sv
// self-checking bench for the descriptor intake
`timescale 1ns/1ps
`default_nettype none
module ddi_intake_tb;
	localparam int MB = 512;
	typedef struct packed {
		logic [31:0] src, dst, len;
		logic [15:0] seq;
		logic [7:0]  rb, wb;
		logic [15:0] rs, ws;
		logic [10:0] erb, ewb;
	} ddi_row_t;
	ddi_row_t rows [3] = '{
		'{32'h1000_0000, 32'h2000_0000, 32'h0000_0040, 16'h0001, 8'h00, 8'h01, 16'h0000, 16'h0001, 11'h200, 11'h001},
		'{32'h1111_0004, 32'h2222_0008, 32'hFFFF_FFFF, 16'h00A2, 8'h80, 8'hC8, 16'h0002, 16'h0000, 11'h080, 11'h080},
		'{32'hCAFE_0010, 32'h0BAD_0020, 32'h0000_0003, 16'h7E03, 8'h81, 8'h7F, 16'hFFFF, 16'h0003, 11'h080, 11'h07F}};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic go = 1'b0;
	logic rd_desc_ready = 1'b0;
	logic wr_desc_ready = 1'b0;
	logic [31:0] be = 32'h0000_0000;
	logic [255:0] data = '0;
	logic agent_write, agent_waitrequest, rd_desc_valid, wr_desc_valid, desc_length_unlimited;
	logic [31:0] agent_byteenable, desc_length, desc_control, desc_rd_stride_bytes, desc_wr_stride_bytes;
	logic [255:0] agent_writedata;
	logic [63:0] desc_src_addr, desc_dst_addr;
	logic [15:0] desc_seq, rd_seq_status, wr_seq_status;
	logic [10:0] desc_rd_burst, desc_wr_burst;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	ddi_intake #(.MAX_BURST(MB)) uut (.clk, .reset, .agent_write, .agent_byteenable, .agent_writedata,
		.agent_waitrequest, .rd_desc_ready, .wr_desc_ready, .rd_desc_valid, .wr_desc_valid, .desc_src_addr,
		.desc_dst_addr, .desc_length, .desc_length_unlimited, .desc_control, .desc_seq, .desc_rd_burst,
		.desc_wr_burst, .desc_rd_stride_bytes, .desc_wr_stride_bytes, .rd_seq_status, .wr_seq_status);
	ddi_writer_model host (.clk, .go, .be, .data, .agent_waitrequest, .agent_write, .agent_byteenable,
		.agent_writedata);
	// standard format, stream-to-memory: the width and mode the main instance never takes
	logic         s_write = 1'b0;
	logic [15:0]  s_be = 16'h0000;
	logic [127:0] s_data = '0;
	logic         s_wait, s_rdv, s_wrv;
	logic [63:0]  s_src, s_dst;
	logic [31:0]  s_ctrl;
	logic [10:0]  s_rb;
	ddi_intake #(.EXTENDED(1'b0), .MODE(ddi_pkg::DDI_ST_TO_MM)) uut_std (.clk, .reset, .agent_write(s_write),
		.agent_byteenable(s_be), .agent_writedata(s_data), .agent_waitrequest(s_wait), .rd_desc_ready,
		.wr_desc_ready, .rd_desc_valid(s_rdv), .wr_desc_valid(s_wrv), .desc_src_addr(s_src),
		.desc_dst_addr(s_dst), .desc_length(), .desc_length_unlimited(), .desc_control(s_ctrl), .desc_seq(),
		.desc_rd_burst(s_rb), .desc_wr_burst(), .desc_rd_stride_bytes(), .desc_wr_stride_bytes(),
		.rd_seq_status(), .wr_seq_status());
	always #50 clk = ~clk;
	task stop_test;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ceiling far above the fifty or so cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			stop_test;
		end
	end
	task check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// returns on the falling edge after the write was taken
	task send(input logic [31:0] b, input logic [255:0] d);
		@(posedge clk);
		be <= b;
		data <= d;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(negedge clk); while (agent_write);
	endtask
	task take;
		@(posedge clk);
		rd_desc_ready <= 1'b1;
		wr_desc_ready <= 1'b1;
		@(posedge clk);
		rd_desc_ready <= 1'b0;
		wr_desc_ready <= 1'b0;
		@(negedge clk);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check(desc_rd_burst, MB, "reset burst");
		check({desc_rd_stride_bytes, desc_wr_stride_bytes}, 64'h0000_0004_0000_0004, "reset strides");
		foreach (rows[i]) begin
			send(32'hFFFF_FFFF, {32'h8000_0000, 32'h0000_005A, 32'h0000_00A5, rows[i].ws, rows[i].rs,
				rows[i].wb, rows[i].rb, rows[i].seq, rows[i].len, rows[i].dst, rows[i].src});
			@(negedge clk);
			check({rd_desc_valid, wr_desc_valid, agent_waitrequest}, 3'h7, "commit");
			check(desc_src_addr, {32'h0000_00A5, rows[i].src}, "source");
			check(desc_dst_addr, {32'h0000_005A, rows[i].dst}, "destination");
			check(desc_length, rows[i].len, "length");
			check(desc_control, 32'h8000_0000, "control");
			check(desc_length_unlimited, rows[i].len == 32'hFFFF_FFFF, "unlimited");
			check(desc_seq, rows[i].seq, "sequence");
			check({desc_rd_burst, desc_wr_burst}, {rows[i].erb, rows[i].ewb}, "bursts");
			check(desc_rd_stride_bytes, {rows[i].rs, 2'h0}, "read stride");
			check(desc_wr_stride_bytes, {rows[i].ws, 2'h0}, "write stride");
			take;
			check({rd_seq_status, agent_waitrequest}, {rows[i].seq, 1'b0}, "taken");
		end
		// source and sequence lanes only: staged, not offered
		send(32'h0000_300F, {144'h0, 16'hBEEF, 64'h0, 32'h1234_5678});
		repeat (3) @(negedge clk);
		check(rd_desc_valid, 1'b0, "no commit");
		send(32'h8000_0000, {8'h80, 248'h0});
		@(negedge clk);
		check(desc_src_addr, {32'h0000_00A5, 32'h1234_5678}, "lane source");
		check(desc_length, rows[2].len, "lane length kept");
		fork
			send(32'h8000_0000, {8'h80, 248'h0});
			begin
				repeat (4) @(negedge clk);
				check({agent_write, agent_waitrequest}, 2'h3, "held write");
				@(posedge clk) rd_desc_ready <= 1'b1;
				@(posedge clk) rd_desc_ready <= 1'b0;
				@(negedge clk);
				check({rd_seq_status, wr_seq_status}, {16'hBEEF, rows[2].seq}, "per host");
				check(agent_waitrequest, 1'b1, "still held");
				@(posedge clk) wr_desc_ready <= 1'b1;
				@(posedge clk) wr_desc_ready <= 1'b0;
			end
		join
		@(negedge clk);
		check({rd_desc_valid, wr_desc_valid}, 2'h3, "second commit");
		take;
		// awkward case: source written although stream-to-memory has none
		@(posedge clk);
		s_be <= 16'hFFFF;
		s_data <= {32'h8000_0001, 32'h0000_0010, 32'h3000_0000, 32'h4000_0000};
		s_write <= 1'b1;
		do @(posedge clk); while (s_wait);
		s_write <= 1'b0;
		@(negedge clk);
		check({s_rdv, s_wrv, s_wait}, 3'h3, "std commit");
		check(s_src, 64'h0000_0000_0000_0000, "std source");
		check(s_dst, 64'h0000_0000_3000_0000, "std destination");
		check(s_ctrl, 32'h8000_0001, "std control");
		check(s_rb, ddi_pkg::MAX_BURST_DEFAULT, "std burst");
		// reset in mid-run drops the held descriptor and the decoded fields
		@(posedge clk) reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check({s_wrv, s_wait, rd_desc_valid, agent_waitrequest}, 4'h0, "reset slot");
		check(desc_src_addr, 64'h0000_0000_0000_0000, "reset source");
		check(rd_seq_status, 16'h0000, "reset status");
		check(desc_rd_burst, MB, "reset burst again");
		check(desc_rd_stride_bytes, 32'h0000_0004, "reset stride again");
		stop_test;
	end
endmodule // ddi_intake_tb
`default_nettype wire
